// *** bench/lpmc_partner.sv ***
/*
  External bus master and external interrupt sources for the mode
  controller. Assumes the bench commands it and shares hclk.
*/
`timescale 1ns/1ps
`default_nettype none
module lpmc_partner (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bench commands
  input wire logic want_bus,
  input wire logic [3:0] irq_req,
  // Bus handshake
  input wire logic bus_grant_ack_n,
  output logic bus_request_n,
  // Interrupt pins, active low
  output logic nmi_n,
  output logic ext_irq_line_a,
  output logic ext_irq_line_b,
  output logic ext_irq_line_c
);
  logic [3:0] hold_q;
  // ----------------------------------------------------------------
  // Bus master
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_request_n <= 1'b1;
      hold_q <= 4'h0;
    end else if (!bus_request_n && !bus_grant_ack_n) begin
      // Short tenure, then negate the request
      hold_q <= hold_q + 4'h1;
      if (hold_q == 4'h3) bus_request_n <= 1'b1;
    end else begin
      hold_q <= 4'h0;
      bus_request_n <= ~want_bus;
    end
  end
  // ----------------------------------------------------------------
  // Interrupt sources, driven high when quiet
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {ext_irq_line_c, ext_irq_line_b, ext_irq_line_a, nmi_n} <= 4'hF;
    end else begin
      {ext_irq_line_c, ext_irq_line_b, ext_irq_line_a, nmi_n} <= ~irq_req;
    end
  end
endmodule // lpmc_partner
`default_nettype wire

// *** bench/lpmc_test.sv ***
/*
  Self-checking bench for the mode controller over AHB-Lite.
  Assumes the partner model drives the wake and bus request pins.
*/
`timescale 1ns/1ps
`default_nettype none
module lpmc_test;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic nmi_n, irq_a, irq_b, irq_c, onchip_irq, bus_request_n;
  logic bus_grant_ack_n, want_bus, svc_seen, c0;
  logic [3:0] irq_req;
  logic [19:0] address_lines, resume_addr;
  logic [5:0] ctrl_pins_n;
  logic address_lines_oe_n, ctrl_pins_oe_n, data_lines_oe_n, halt_n;
  logic cycle_status_out, system_clock_out, core_clk_en, dma_clk_en;
  logic periph_clk_en, refresh_en, irq_service;
  int fails, samples_checked, cyc, n1, n2;
  assign hready = hreadyout;
  lpmc_top lpmc_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .nmi_n(nmi_n),
    .ext_irq_line_a(irq_a), .ext_irq_line_b(irq_b),
    .ext_irq_line_c(irq_c), .onchip_irq(onchip_irq),
    .bus_request_n(bus_request_n), .bus_grant_ack_n(bus_grant_ack_n),
    .core_addr(20'h12345), .core_ctrl_n(6'h2A), .core_status(1'b0),
    .core_data_oe_n(1'b0), .address_lines(address_lines),
    .address_lines_oe_n(address_lines_oe_n), .ctrl_pins_n(ctrl_pins_n),
    .ctrl_pins_oe_n(ctrl_pins_oe_n), .data_lines_oe_n(data_lines_oe_n),
    .halt_n(halt_n), .cycle_status_out(cycle_status_out),
    .system_clock_out(system_clock_out), .core_clk_en(core_clk_en),
    .dma_clk_en(dma_clk_en), .periph_clk_en(periph_clk_en),
    .refresh_en(refresh_en), .irq_service(irq_service),
    .resume_addr(resume_addr));
  lpmc_partner lpmc_partner_inst (.hclk(hclk), .hresetn(hresetn),
    .want_bus(want_bus), .irq_req(irq_req),
    .bus_grant_ack_n(bus_grant_ack_n), .bus_request_n(bus_request_n),
    .nmi_n(nmi_n), .ext_irq_line_a(irq_a), .ext_irq_line_b(irq_b),
    .ext_irq_line_c(irq_c));
  // ----------------------------------------------------------------
  // Clock, timeout, service monitor
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (irq_service === 1'b1) svc_seen = 1'b1;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tick();
    @(posedge hclk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  // Master holds each phase until hready is sampled high
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic wait_mode(input logic [1:0] m);
    int k;
    k = 0;
    do begin
      xfer(1'b0, lpmc_pkg::OFS_STATUS, 32'h0);
      k++;
    end while (rd[1:0] !== m && k < 60);
    chk("mode", {30'h0, m}, {30'h0, rd[1:0]});
  endtask
  task automatic cmd(input logic [19:0] a, input logic [2:0] op);
    wr(lpmc_pkg::OFS_CMD, {4'h0, a, 5'h00, op});
  endtask
  task automatic measure_grant(output int n);
    want_bus <= 1'b1;
    n = 0;
    while (bus_grant_ack_n !== 1'b0 && n < 100) begin
      tick();
      n++;
    end
    want_bus <= 1'b0;
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    {onchip_irq, want_bus, svc_seen, irq_req} = '0;
    fails = 0;
    samples_checked = 0;
    cyc = 0;
    hresetn = 1'b0;
    repeat (6) tick();
    chk("status_rst", 32'h1, {31'h0, cycle_status_out});
    chk("addr_oe_rst", 32'h1, {31'h0, address_lines_oe_n});
    chk("data_oe_rst", 32'h1, {31'h0, data_lines_oe_n});
    hresetn <= 1'b1;
    xfer(1'b0, lpmc_pkg::OFS_CTRL, 32'h0);
    chk("ctrl_rst", {24'h0, lpmc_pkg::CTRL_RESET}, rd);
    xfer(1'b0, lpmc_pkg::OFS_IRQ_EN, 32'h0);
    chk("en_rst", {28'h0, lpmc_pkg::IRQ_EN_RESET}, rd);
    wr(8'h14, 32'hFFFFFFFF);
    xfer(1'b0, 8'h14, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("addr_run", 32'h12345, {12'h0, address_lines});
    $display("test registers done");
    // Sleep with only line a enabled, global flag clear
    wr(lpmc_pkg::OFS_IRQ_EN, 32'h2);
    cmd(20'h00100, lpmc_pkg::OP_SLEEP);
    wait_mode(2'h2);
    tick();
    chk("addr_slp", 32'hFFFFF, {12'h0, address_lines});
    chk("addr_oe_slp", 32'h0, {31'h0, address_lines_oe_n});
    chk("ctrl_slp", 32'h3F, {26'h0, ctrl_pins_n});
    chk("ctrl_oe_slp", 32'h0, {31'h0, ctrl_pins_oe_n});
    chk("halt_slp", 32'h0, {31'h0, halt_n});
    chk("status_slp", 32'h1, {31'h0, cycle_status_out});
    chk("data_oe_slp", 32'h1, {31'h0, data_lines_oe_n});
    chk("clk_en", 32'h2, {28'h0, core_clk_en, dma_clk_en, periph_clk_en,
        refresh_en});
    c0 = system_clock_out;
    tick();
    chk("clk_pin", {31'h0, ~c0}, {31'h0, system_clock_out});
    irq_req <= 4'b0100;
    repeat (10) tick();
    irq_req <= 4'h0;
    wait_mode(2'h2);
    measure_grant(n1);
    chk("ack_slp", 32'h0, {31'h0, bus_grant_ack_n});
    tick();
    chk("addr_oe_ack", 32'h1, {31'h0, address_lines_oe_n});
    chk("data_oe_ack", 32'h1, {31'h0, data_lines_oe_n});
    chk("ctrl_oe_ack", 32'h1, {31'h0, ctrl_pins_oe_n});
    chk("status_ack", 32'h1, {31'h0, cycle_status_out});
    repeat (12) tick();
    svc_seen = 1'b0;
    irq_req <= 4'b0010;
    wait_mode(2'h0);
    irq_req <= 4'h0;
    xfer(1'b0, lpmc_pkg::OFS_RESUME, 32'h0);
    chk("resume_slp", 32'h00102, rd);
    chk("svc_off", 32'h0, {31'h0, svc_seen});
    $display("test sleep done");
    // Wake with global flag set, on-chip source
    cmd(20'h0, lpmc_pkg::OP_IRQ_ON);
    wr(lpmc_pkg::OFS_IRQ_EN, 32'h1);
    cmd(20'h00200, lpmc_pkg::OP_SLEEP);
    wait_mode(2'h2);
    svc_seen = 1'b0;
    onchip_irq <= 1'b1;
    wait_mode(2'h0);
    onchip_irq <= 1'b0;
    xfer(1'b0, lpmc_pkg::OFS_RESUME, 32'h0);
    chk("resume_svc", 32'h00202, rd);
    chk("svc_on", 32'h1, {31'h0, svc_seen});
    chk("resume_pin", 32'h00202, {12'h0, resume_addr});
    // Halt, woken by the non-maskable request
    wr(lpmc_pkg::OFS_IRQ_EN, 32'h0);
    cmd(20'h00300, lpmc_pkg::OP_HALT);
    wait_mode(2'h1);
    svc_seen = 1'b0;
    irq_req <= 4'b0001;
    wait_mode(2'h0);
    irq_req <= 4'h0;
    xfer(1'b0, lpmc_pkg::OFS_RESUME, 32'h0);
    chk("resume_halt", 32'h00301, rd);
    chk("svc_halt", 32'h1, {31'h0, svc_seen});
    cmd(20'h0, lpmc_pkg::OP_IRQ_OFF);
    xfer(1'b0, lpmc_pkg::OFS_STATUS, 32'h0);
    chk("flag_off", 32'h0, {31'h0, rd[lpmc_pkg::STAT_IRQ_FLAG]});
    $display("test wake done");
    // Grant latency, normal against idle
    measure_grant(n1);
    repeat (12) tick();
    wr(lpmc_pkg::OFS_CTRL, 32'h01);
    cmd(20'h00400, lpmc_pkg::OP_SLEEP);
    wait_mode(2'h3);
    want_bus <= 1'b1;
    repeat (40) tick();
    chk("ack_idle_off", 32'h1, {31'h0, bus_grant_ack_n});
    chk("clk_idle", 32'h0, {31'h0, system_clock_out});
    want_bus <= 1'b0;
    irq_req <= 4'b0001;
    wait_mode(2'h0);
    irq_req <= 4'h0;
    wr(lpmc_pkg::OFS_CTRL, 32'h21);
    cmd(20'h00500, lpmc_pkg::OP_SLEEP);
    wait_mode(2'h3);
    measure_grant(n2);
    chk("idle_delay", n1 + 8, n2);
    repeat (12) tick();
    chk("clk_stop", 32'h0, {31'h0, system_clock_out});
    tick();
    chk("clk_stop2", 32'h0, {31'h0, system_clock_out});
    wait_mode(2'h3);
    irq_req <= 4'b0001;
    wait_mode(2'h0);
    irq_req <= 4'h0;
    $display("test grant done");
    // Reset ends halt
    cmd(20'h00600, lpmc_pkg::OP_HALT);
    wait_mode(2'h1);
    hresetn <= 1'b0;
    repeat (2) tick();
    chk("halt_rst", 32'h1, {31'h0, halt_n});
    hresetn <= 1'b1;
    wait_mode(2'h0);
    $display("test reset done");
    finish_test();
  end
endmodule // lpmc_test
`default_nettype wire

// *** logic/lpmc_sync.sv ***
/*
  Two-flop level synchroniser for one input.
  Assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module lpmc_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Level in and out
  input wire logic din,
  output logic dout
);
  logic meta_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= RESET_VAL;
      dout <= RESET_VAL;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule // lpmc_sync
`default_nettype wire

// *** logic/lpmc_top.sv ***
/*
  Low-power mode controller: HALT, SLEEP and IDLE entry and exit, bus
  granting while asleep, and pin states during reset, grant and sleep.
  Assumes an AHB-Lite master for software, a CPU core that supplies its
  own bus pin values while running, and on-chip peripheral requests.
*/
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
// Overview of operation
// - HALT ends on reset, NMI, or enabled on-chip or external request.
// - Interrupt out of HALT returns to address after halt instruction.
// - Sleep instruction enters SLEEP when stop, recovery, standby bits zero.
// - In SLEEP oscillator and clock pin run; core and DMA clocks gated.
// - In SLEEP refresh stops; interrupts and bus grants still work.
// - SLEEP without grant drives address and controls high, halt low.
// - In SLEEP peripherals keep running, DMA channels are suspended.
// - SLEEP ends on reset, on-chip request, NMI or external lines.
// - A source with its enable cleared cannot end SLEEP.
// - Wake with global flag set services interrupt, returns after sleep.
// - Wake by an enabled source with global flag clear continues after sleep instruction; NMI is still serviced.
// - In IDLE the bus is granted only when bus release bit is one.
// - In IDLE a bus request is answered eight cycles later than normal.
// - After master drops request, output clock stops and IDLE stays.
// - Status output is high during reset, bus grant and sleep.
// - NMI and external request pins stay inputs in every mode.
`timescale 1ns/1ps
`default_nettype none
module lpmc_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Wake sources, pins are inputs only
  input wire logic nmi_n,
  input wire logic ext_irq_line_a,
  input wire logic ext_irq_line_b,
  input wire logic ext_irq_line_c,
  input wire logic onchip_irq,
  // External bus master
  input wire logic bus_request_n,
  output logic bus_grant_ack_n,
  // Core side pin values while running
  input wire logic [19:0] core_addr,
  input wire logic [5:0] core_ctrl_n,
  input wire logic core_status,
  input wire logic core_data_oe_n,
  // Pins
  output logic [19:0] address_lines,
  output logic address_lines_oe_n,
  output logic [5:0] ctrl_pins_n,
  output logic ctrl_pins_oe_n,
  output logic data_lines_oe_n,
  output logic halt_n,
  output logic cycle_status_out,
  output logic system_clock_out,
  // Clock gating and core hand-off
  output logic core_clk_en,
  output logic dma_clk_en,
  output logic periph_clk_en,
  output logic refresh_en,
  output logic irq_service,
  output logic [19:0] resume_addr
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic nmi_s, line_a_s, line_b_s, line_c_s, breq_s;

  lpmc_sync #(.RESET_VAL(1'b1)) u_sync_nmi (
    .hclk(hclk), .hresetn(hresetn), .din(nmi_n), .dout(nmi_s));
  lpmc_sync #(.RESET_VAL(1'b1)) u_sync_a (
    .hclk(hclk), .hresetn(hresetn), .din(ext_irq_line_a), .dout(line_a_s));
  lpmc_sync #(.RESET_VAL(1'b1)) u_sync_b (
    .hclk(hclk), .hresetn(hresetn), .din(ext_irq_line_b), .dout(line_b_s));
  lpmc_sync #(.RESET_VAL(1'b1)) u_sync_c (
    .hclk(hclk), .hresetn(hresetn), .din(ext_irq_line_c), .dout(line_c_s));
  lpmc_sync #(.RESET_VAL(1'b1)) u_sync_breq (
    .hclk(hclk), .hresetn(hresetn), .din(bus_request_n), .dout(breq_s));

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic [3:0] irq_en_q;
  logic irq_flag_q;
  logic wake_seen_q;
  logic wr_pend_q;
  logic [7:0] wr_ofs_q;
  logic addr_ok;
  logic cmd_strobe;
  logic [2:0] cmd_op;
  logic [19:0] cmd_addr;
  lpmc_pkg::lpmc_mode_t mode_q;
  logic grant_q;

  assign addr_ok = hsel && hready && htrans[1];
  assign cmd_strobe = wr_pend_q && (wr_ofs_q == lpmc_pkg::OFS_CMD);
  assign cmd_op = hwdata[2:0];
  assign cmd_addr = hwdata[lpmc_pkg::CMD_ADDR_LSB +: 20];

  // Zero-wait slave, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_ofs_q <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= addr_ok && hwrite;
      wr_ofs_q <= haddr[7:0];
    end
  end

  // Read data loads at the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      unique case (haddr[7:0])
        lpmc_pkg::OFS_CTRL: hrdata <= {24'h00_0000, ctrl_q};
        lpmc_pkg::OFS_IRQ_EN: hrdata <= {28'h000_0000, irq_en_q};
        lpmc_pkg::OFS_STATUS:
          hrdata <= {27'h000_0000, wake_seen_q, grant_q, irq_flag_q,
                     mode_q};
        lpmc_pkg::OFS_RESUME: hrdata <= {12'h000, resume_addr};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= lpmc_pkg::CTRL_RESET;
      irq_en_q <= lpmc_pkg::IRQ_EN_RESET;
    end else if (wr_pend_q) begin
      if (wr_ofs_q == lpmc_pkg::OFS_CTRL) begin
        ctrl_q <= hwdata[7:0];
      end
      if (wr_ofs_q == lpmc_pkg::OFS_IRQ_EN) begin
        irq_en_q <= hwdata[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Wake sources
  // ----------------------------------------------------------------
  logic nmi_req, mask_req, wake;

  // Individually disabled sources are masked before they can wake
  assign mask_req = (onchip_irq && irq_en_q[lpmc_pkg::EN_ONCHIP])
                  || (!line_a_s && irq_en_q[lpmc_pkg::EN_LINE_A])
                  || (!line_b_s && irq_en_q[lpmc_pkg::EN_LINE_B])
                  || (!line_c_s && irq_en_q[lpmc_pkg::EN_LINE_C]);
  assign nmi_req = !nmi_s;
  assign wake = nmi_req || mask_req;

  // ----------------------------------------------------------------
  // Mode machine
  // ----------------------------------------------------------------
  logic sleep_ok, idle_ok, asleep;
  logic [19:0] next_addr_q;

  assign sleep_ok = !ctrl_q[lpmc_pkg::CTRL_PERIPH_STOP]
                 && !ctrl_q[lpmc_pkg::CTRL_RECOVERY]
                 && !ctrl_q[lpmc_pkg::CTRL_STANDBY];
  // Standby combinations are not handled here and leave the core running
  assign idle_ok = ctrl_q[lpmc_pkg::CTRL_PERIPH_STOP]
                && !ctrl_q[lpmc_pkg::CTRL_STANDBY];
  assign asleep = (mode_q == lpmc_pkg::MODE_SLEEP)
               || (mode_q == lpmc_pkg::MODE_IDLE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= lpmc_pkg::MODE_RUN;
      next_addr_q <= 20'h00000;
      irq_service <= 1'b0;
      resume_addr <= 20'h00000;
      wake_seen_q <= 1'b0;
    end else begin
      irq_service <= 1'b0;
      unique case (mode_q)
        lpmc_pkg::MODE_RUN: begin
          if (cmd_strobe && cmd_op == lpmc_pkg::OP_HALT) begin
            mode_q <= lpmc_pkg::MODE_HALT;
            next_addr_q <= cmd_addr + lpmc_pkg::HALT_LEN;
          end else if (cmd_strobe && cmd_op == lpmc_pkg::OP_SLEEP) begin
            if (sleep_ok) begin
              mode_q <= lpmc_pkg::MODE_SLEEP;
            end else if (idle_ok) begin
              mode_q <= lpmc_pkg::MODE_IDLE;
            end
            next_addr_q <= cmd_addr + lpmc_pkg::SLEEP_LEN;
          end
        end
        lpmc_pkg::MODE_HALT, lpmc_pkg::MODE_SLEEP,
        lpmc_pkg::MODE_IDLE: begin
          if (wake) begin
            mode_q <= lpmc_pkg::MODE_RUN;
            resume_addr <= next_addr_q;
            wake_seen_q <= 1'b1;
            // NMI is always taken; masked sources need the global flag
            irq_service <= nmi_req || irq_flag_q;
          end
        end
      endcase
    end
  end

  // Global flag, set and cleared by the enable/disable instructions
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_flag_q <= 1'b0;
    end else if (cmd_strobe && mode_q == lpmc_pkg::MODE_RUN) begin
      if (cmd_op == lpmc_pkg::OP_IRQ_ON) begin
        irq_flag_q <= 1'b1;
      end else if (cmd_op == lpmc_pkg::OP_IRQ_OFF) begin
        irq_flag_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus grant
  // ----------------------------------------------------------------
  logic breq, grant_allowed;
  logic [3:0] idle_cnt_q;

  assign breq = !breq_s;
  assign grant_allowed = (mode_q != lpmc_pkg::MODE_IDLE)
                      || ctrl_q[lpmc_pkg::CTRL_BUS_RELEASE];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      grant_q <= 1'b0;
      idle_cnt_q <= 4'h0;
    end else if (!grant_q) begin
      if (breq && grant_allowed) begin
        // IDLE wakes the bus logic first, so the answer runs longer
        if (mode_q != lpmc_pkg::MODE_IDLE
            || idle_cnt_q == lpmc_pkg::IDLE_GRANT_EXTRA) begin
          grant_q <= 1'b1;
          idle_cnt_q <= 4'h0;
        end else begin
          idle_cnt_q <= idle_cnt_q + 4'h1;
        end
      end else begin
        idle_cnt_q <= 4'h0;
      end
    end else if (!breq) begin
      grant_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pins and clock enables
  // ----------------------------------------------------------------
  logic phi_run;

  // Clock pin stops in IDLE once the master has let go
  assign phi_run = (mode_q != lpmc_pkg::MODE_IDLE)
                || grant_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      system_clock_out <= 1'b0;
      core_clk_en <= 1'b0;
      dma_clk_en <= 1'b0;
      periph_clk_en <= 1'b0;
      refresh_en <= 1'b0;
    end else begin
      system_clock_out <= phi_run ? !system_clock_out : 1'b0;
      core_clk_en <= (mode_q == lpmc_pkg::MODE_RUN);
      dma_clk_en <= !asleep;
      periph_clk_en <= (mode_q != lpmc_pkg::MODE_IDLE);
      refresh_en <= !asleep;
    end
  end

  // Reset values float the buses and hold status high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_grant_ack_n <= 1'b1;
      address_lines <= lpmc_pkg::ADDR_HIGH;
      address_lines_oe_n <= 1'b1;
      ctrl_pins_n <= lpmc_pkg::CTRL_PINS_HIGH;
      ctrl_pins_oe_n <= 1'b1;
      data_lines_oe_n <= 1'b1;
      halt_n <= 1'b1;
      cycle_status_out <= 1'b1;
    end else begin
      bus_grant_ack_n <= !grant_q;
      halt_n <= (mode_q == lpmc_pkg::MODE_RUN) || grant_q;
      if (grant_q) begin
        address_lines_oe_n <= 1'b1;
        ctrl_pins_oe_n <= 1'b1;
        data_lines_oe_n <= 1'b1;
        cycle_status_out <= 1'b1;
      end else if (asleep) begin
        address_lines <= lpmc_pkg::ADDR_HIGH;
        address_lines_oe_n <= 1'b0;
        ctrl_pins_n <= lpmc_pkg::CTRL_PINS_HIGH;
        ctrl_pins_oe_n <= 1'b0;
        data_lines_oe_n <= 1'b1;
        cycle_status_out <= 1'b1;
      end else begin
        address_lines <= core_addr;
        address_lines_oe_n <= 1'b0;
        ctrl_pins_n <= core_ctrl_n;
        ctrl_pins_oe_n <= 1'b0;
        data_lines_oe_n <= core_data_oe_n;
        cycle_status_out <= core_status;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_sleep_pins;
    (mode_q == lpmc_pkg::MODE_SLEEP && !grant_q) |=>
      (address_lines == 20'hFFFFF && !address_lines_oe_n && !halt_n
       && ctrl_pins_n == 6'h3F);
  endproperty
  a_sleep_pins: assert property (p_sleep_pins)
    else $error("sleep pin levels wrong");

  property p_status_high;
    (grant_q || asleep) |=> cycle_status_out;
  endproperty
  a_status_high: assert property (p_status_high)
    else $error("status low during grant or sleep");

  property p_core_gated;
    (mode_q == lpmc_pkg::MODE_SLEEP) |=> (!core_clk_en && !dma_clk_en
                                && periph_clk_en);
  endproperty
  a_core_gated: assert property (p_core_gated)
    else $error("clock gating wrong in sleep");

  property p_no_refresh;
    asleep ##1 asleep |-> !refresh_en;
  endproperty
  a_no_refresh: assert property (p_no_refresh)
    else $error("refresh active while asleep");

  property p_masked_no_wake;
    (mode_q == lpmc_pkg::MODE_SLEEP && !nmi_req && !mask_req) |=>
      (mode_q == lpmc_pkg::MODE_SLEEP);
  endproperty
  a_masked_no_wake: assert property (p_masked_no_wake)
    else $error("disabled source left sleep");

  property p_idle_no_release;
    (mode_q == lpmc_pkg::MODE_IDLE && !grant_q
     && !ctrl_q[lpmc_pkg::CTRL_BUS_RELEASE]) |=> !grant_q;
  endproperty
  a_idle_no_release: assert property (p_idle_no_release)
    else $error("grant in idle without release bit");

  property p_idle_delay;
    ($rose(grant_q) && mode_q == lpmc_pkg::MODE_IDLE) |->
      ($past(idle_cnt_q) == lpmc_pkg::IDLE_GRANT_EXTRA);
  endproperty
  a_idle_delay: assert property (p_idle_delay)
    else $error("idle grant delay wrong");

  property p_wake_service;
    (asleep && wake && irq_flag_q) |=>
      (irq_service && mode_q == lpmc_pkg::MODE_RUN
       && resume_addr == $past(next_addr_q));
  endproperty
  a_wake_service: assert property (p_wake_service)
    else $error("wake did not service interrupt");

  property p_wake_plain;
    (asleep && mask_req && !nmi_req && !irq_flag_q) |=>
      (!irq_service && mode_q == lpmc_pkg::MODE_RUN);
  endproperty
  a_wake_plain: assert property (p_wake_plain)
    else $error("interrupt taken with global flag clear");

  property p_grant_float;
    grant_q |=> (address_lines_oe_n && data_lines_oe_n && !bus_grant_ack_n);
  endproperty
  a_grant_float: assert property (p_grant_float)
    else $error("pins driven during grant");

endmodule // lpmc_top
`default_nettype wire

// *** pkg/lpmc_pkg.sv ***
/*
  Constants for the low-power mode controller: register offsets, field
  positions, reset values, command codes, mode states and timing counts.
  Assumes a 10 MHz system clock and a 32-bit AHB-Lite register bus.
*/
package lpmc_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_IRQ_EN = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_RESUME = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_PERIPH_STOP = 0;
  localparam int CTRL_RECOVERY = 3;
  localparam int CTRL_BUS_RELEASE = 5;
  localparam int CTRL_STANDBY = 6;
  localparam int EN_ONCHIP = 0;
  localparam int EN_LINE_A = 1;
  localparam int EN_LINE_B = 2;
  localparam int EN_LINE_C = 3;
  localparam int CMD_ADDR_LSB = 8;
  localparam int STAT_IRQ_FLAG = 2;
  localparam int STAT_GRANT = 3;
  localparam int STAT_WAKE_SEEN = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [3:0] IRQ_EN_RESET = 4'h0;
  localparam logic [19:0] ADDR_HIGH = 20'hFFFFF;
  localparam logic [5:0] CTRL_PINS_HIGH = 6'h3F;

  // ----------------------------------------------------------------
  // Command codes and instruction lengths
  // ----------------------------------------------------------------
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_HALT = 3'h1;
  localparam logic [2:0] OP_SLEEP = 3'h2;
  localparam logic [2:0] OP_IRQ_ON = 3'h3;
  localparam logic [2:0] OP_IRQ_OFF = 3'h4;
  localparam logic [19:0] HALT_LEN = 20'h00001;
  localparam logic [19:0] SLEEP_LEN = 20'h00002;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam logic [3:0] IDLE_GRANT_EXTRA = 4'h8;

  // ----------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_HALT,
    MODE_SLEEP,
    MODE_IDLE
  } lpmc_mode_t;

endpackage
